// ---- design/eep_pkg.sv ----
// Shared constants, state codes and carrier types of the serial EEPROM command and protection block.
package eep_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_MS * (CLK_FREQ_HZ / 1000);

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int ADDR_W_DEF = 14;
  localparam int PAGE_BITS = 6;
  localparam int PAGE_BYTES = 64;

  // ----------------------------------------
  // Opcodes, compared after masking bit 3
  // ----------------------------------------
  localparam logic [7:0] OP_MASK = 8'hf7;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  // ----------------------------------------
  // Status register layout and reset values
  // ----------------------------------------
  localparam int SR_BUSY_POS = 0;
  localparam int SR_WEL_POS = 1;
  localparam int SR_BP_LO_POS = 2;
  localparam int SR_BP_HI_POS = 3;
  localparam int SR_HWPE_POS = 7;
  localparam logic [7:0] SR_BUSY_VALUE = 8'hff;
  localparam logic SR_WEL_RST = 1'b0;
  localparam logic [1:0] SR_BP_RST = 2'h0;
  localparam logic SR_HWPE_RST = 1'b0;
  // Resting levels of {chip select, SCK, SI, pause, protect}, so reset makes no false pin edge.
  localparam logic [4:0] PIN_IDLE = 5'h13;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD = 3'b001,
    S_ADDR = 3'b011,
    S_RDATA = 3'b010,
    S_WDATA = 3'b110,
    S_SDATA = 3'b111,
    S_STAT = 3'b101,
    S_DROP = 3'b100
  } eep_state_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } eep_mem_req_type;
endpackage

// ---- design/eep_sync.sv ----
// Two-stage pin synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
module eep_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] async_in, // Pins from outside the clock domain.
  output logic [W-1:0] level, // Synchronised level.
  output logic [W-1:0] rise, // One-cycle pulse on a rising level.
  output logic [W-1:0] fall // One-cycle pulse on a falling level.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
      last_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule // eep_sync

// ---- design/eep_wtimer.sv ----
// Self-timed write cycle counter.
`timescale 1ns/1ps
module eep_wtimer #(
  parameter int CYCLES = 500000
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic start, // Pulse that begins a write cycle.
  output logic busy, // High for the whole write cycle.
  output logic done // One-cycle pulse in the last busy cycle.
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end
    else if (start && !busy_ff)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b1;
    end
    else if (busy_ff)
    begin
      cnt_ff <= cnt_ff + CW'(1);
      busy_ff <= (cnt_ff != LAST);
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff && (cnt_ff == LAST);
endmodule // eep_wtimer

// ---- design/eep_core.sv ----
// Serial command decoder, status register and protection logic of the SPI EEPROM slave.
//
// Notes on behaviour
// - Pause releases only while SCK low; sequence does not advance while paused.
// - While paused SO is released and SI is ignored.
// - Status writes refused when protect pin low and protect enable set.
// - Protect pin falling with chip select low and protect enable set aborts pending status write.
// - Bytes travel MSB first; chip select fall starts with an opcode byte.
// - Decode set latch, clear latch and read status, bit 3 ignored.
// - Decode write status, array read and array write, bit 3 ignored.
// - Write latch is clear after power-up.
// - Clear latch disables programming regardless of protect pin.
// - Status shows latch bit 1, protect bits 3..2, enable bit 7.
// - Status bit 0 is 1 while a write cycle runs.
// - Bits 6..4 read 0 when idle; all bits read 1 while busy.
// - Small variant: protect none, top quarter, top half or all.
// - Large variant uses the same levels; protected addresses refuse writes.
// - Protect bits are nonvolatile, need the latch and a timed cycle.
// - Status write needs latch and (enable clear or protect pin high).
// - Protect enable cannot return to 0 while protect pin stays low.
// - Read takes 16 address bits, keeps low 14 or 15, ignores SI.
// - Read address increments per byte and wraps to zero.
// - Programming starts at chip select rise with SCK low after a byte.
// - Page write increments low 6 address bits, wrapping inside the page.
// - During a write cycle only read status is accepted.
// - Write with latch clear is ignored until chip select rises.
// - Write latch clears when any write cycle completes.
// - Unknown opcode: ignore input, SO released until next chip select fall.
// - Chip select high: SI ignored, SO released.
`timescale 1ns/1ps
module eep_core #(
  parameter int ADDR_W = eep_pkg::ADDR_W_DEF,
  parameter int WC_CYCLES = eep_pkg::WRITE_CYCLE_CYCLES
) (
  input wire logic CORE_CLK, // Core clock.
  input wire logic NRST, // Asynchronous reset, active low.
  input wire logic CS_N, // Chip select pin, active low.
  input wire logic SCK, // Serial clock pin.
  input wire logic SI, // Serial data in pin.
  input wire logic HOLD_N, // Pause pin, active low.
  input wire logic WP_N, // Write protect pin, active low.
  output logic SO, // Serial data out pin value.
  output logic SO_OE, // Serial data out drive enable.
  output eep_pkg::eep_mem_req_type MEM_REQ, // Array address and write strobe.
  input wire logic [7:0] MEM_RD_DATA, // Array byte at MEM_REQ.addr.
  output logic BUSY // Write cycle in progress.
);
  import eep_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [4:0] pin_lv;
  logic [4:0] pin_rs;
  logic [4:0] pin_fl;

  eep_sync #(.W(5), .RST_VAL(PIN_IDLE)) u_sync (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .async_in({CS_N, SCK, SI, HOLD_N, WP_N}),
    .level(pin_lv),
    .rise(pin_rs),
    .fall(pin_fl)
  );

  wire cs_n_s = pin_lv[4];
  wire sck_s = pin_lv[3];
  wire si_s = pin_lv[2];
  wire hold_n_s = pin_lv[1];
  wire wp_n_s = pin_lv[0];
  wire cs_fall = pin_fl[4];
  wire cs_rise = pin_rs[4];
  wire wp_fall = pin_fl[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  eep_state_type state_ff;
  eep_state_type nxt_state;
  logic paused_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic [15:0] addr_ff;
  logic addr_hi_ff;
  logic op_wr_ff;
  logic wel_ff;
  logic [1:0] bp_ff;
  logic hwpe_ff;
  logic [7:0] stat_new_ff;
  logic sdata_got_ff;
  logic kind_stat_ff;
  logic [PAGE_BYTES-1:0] page_vld_ff;
  logic [7:0] page_mem [PAGE_BYTES];
  logic drain_ff;
  logic [PAGE_BITS-1:0] drain_idx_ff;
  logic [15-PAGE_BITS:0] page_base_ff;
  eep_mem_req_type mem_req_ff;
  logic [7:0] out_shift_ff;
  logic so_ff;
  logic tx_started_ff;
  logic so_oe_ff;
  logic busy;
  logic wr_done;

  // ----------------------------------------
  // Serial edges and byte assembly
  // ----------------------------------------
  // A pause is entered or left only while SCK is low; edges are dropped meanwhile.
  wire nxt_paused = cs_n_s ? 1'b0 : (!sck_s ? !hold_n_s : paused_ff);
  wire active = !cs_n_s && !cs_fall && !paused_ff;
  wire rx_edge = active && pin_rs[3];
  wire tx_edge = active && pin_fl[3];
  wire [7:0] rx_byte = {shift_ff, si_s};
  wire byte_done = rx_edge && (bit_cnt_ff == 3'h7);
  wire [7:0] op_m = rx_byte & OP_MASK;
  wire is_set = (op_m == OP_SET_WRITE_LATCH);
  wire is_clr = (op_m == OP_CLEAR_WRITE_LATCH);
  wire is_read_status_cmd = (op_m == OP_READ_STATUS);
  wire is_write_status_cmd = (op_m == OP_WRITE_STATUS);
  wire is_read = (op_m == OP_ARRAY_READ);
  wire is_write = (op_m == OP_ARRAY_WRITE);
  wire cmd_done = byte_done && (state_ff == S_CMD);
  wire tx_state = (state_ff == S_RDATA) || (state_ff == S_STAT);

  // ----------------------------------------
  // Address arithmetic and protection
  // ----------------------------------------
  localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_W) - 1);
  wire [15:0] addr_rd_inc = (addr_ff + 16'h1) & ADDR_MASK;
  wire [PAGE_BITS-1:0] page_off = addr_ff[PAGE_BITS-1:0];
  wire [PAGE_BITS-1:0] page_off_inc = page_off + PAGE_BITS'(1);
  wire [15:0] drain_addr = {page_base_ff, drain_idx_ff} & ADDR_MASK;

  function automatic logic is_protected(input logic [15:0] a, input logic [1:0] bp);
    logic top1;
    logic top2;
    top1 = a[ADDR_W-1];
    top2 = a[ADDR_W-2];
    unique case (bp)
      2'h0: is_protected = 1'b0;
      2'h1: is_protected = top1 && top2;
      2'h2: is_protected = top1;
      2'h3: is_protected = 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // Write cycle launch
  // ----------------------------------------
  wire stat_wr_ok = !hwpe_ff || wp_n_s;
  // Chip select must rise with SCK low on a byte boundary.
  wire edge_ok = cs_rise && !sck_s && (bit_cnt_ff == 3'h0) && wel_ff && !busy;
  wire arr_go = edge_ok && (state_ff == S_WDATA) && (|page_vld_ff);
  wire stat_go = edge_ok && (state_ff == S_SDATA) && sdata_got_ff && stat_wr_ok;
  wire wr_go = arr_go || stat_go;

  eep_wtimer #(.CYCLES(WC_CYCLES)) u_wtimer (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .start(wr_go),
    .busy(busy),
    .done(wr_done)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  logic [7:0] status_byte;
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[SR_WEL_POS] = wel_ff;
    status_byte[SR_BP_LO_POS] = bp_ff[0];
    status_byte[SR_BP_HI_POS] = bp_ff[1];
    status_byte[SR_HWPE_POS] = hwpe_ff;
    status_byte[SR_BUSY_POS] = 1'b0;
    if (busy)
    begin
      status_byte = SR_BUSY_VALUE;
    end
  end

  wire [7:0] tx_byte = (state_ff == S_STAT) ? status_byte : MEM_RD_DATA;

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    if (cs_n_s)
    begin
      nxt_state = S_IDLE;
    end
    else if (cs_fall)
    begin
      nxt_state = S_CMD;
    end
    else if ((state_ff == S_SDATA) && wp_fall && hwpe_ff)
    begin
      nxt_state = S_DROP;
    end
    else if (byte_done)
    begin
      unique case (state_ff)
        S_CMD:
        begin
          if (is_read_status_cmd)
            nxt_state = S_STAT;
          else if (busy)
            nxt_state = S_DROP;
          else if (is_read)
            nxt_state = S_ADDR;
          else if ((is_write || is_write_status_cmd) && !wel_ff)
            nxt_state = S_DROP;
          else if (is_write)
            nxt_state = S_ADDR;
          else if (is_write_status_cmd)
            nxt_state = S_SDATA;
          else
            nxt_state = S_DROP;
        end
        S_ADDR:
        begin
          if (addr_hi_ff)
            nxt_state = op_wr_ff ? S_WDATA : S_RDATA;
        end
        default:
        begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_ff <= S_IDLE;
      paused_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      paused_ff <= nxt_paused;
      bit_cnt_ff <= cs_fall ? 3'h0 : (rx_edge ? bit_cnt_ff + 3'h1 : bit_cnt_ff);
      shift_ff <= rx_edge ? rx_byte[6:0] : shift_ff;
    end
  end

  // ----------------------------------------
  // Address register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      addr_ff <= 16'h0000;
      addr_hi_ff <= 1'b0;
      op_wr_ff <= 1'b0;
    end
    else if (cmd_done)
    begin
      addr_hi_ff <= 1'b0;
      op_wr_ff <= is_write;
    end
    else if (byte_done && (state_ff == S_ADDR))
    begin
      addr_ff <= {addr_ff[7:0], rx_byte} & ADDR_MASK;
      addr_hi_ff <= 1'b1;
    end
    else if (byte_done && (state_ff == S_RDATA))
    begin
      addr_ff <= addr_rd_inc;
    end
    else if (byte_done && (state_ff == S_WDATA))
    begin
      addr_ff <= {addr_ff[15:PAGE_BITS], page_off_inc};
    end
  end

  // ----------------------------------------
  // Write latch and nonvolatile status bits
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wel_ff <= SR_WEL_RST;
      bp_ff <= SR_BP_RST;
      hwpe_ff <= SR_HWPE_RST;
    end
    else
    begin
      if (cmd_done && !busy && is_set)
        wel_ff <= 1'b1;
      else if ((cmd_done && !busy && is_clr) || wr_done)
        wel_ff <= 1'b0;
      if (wr_done && kind_stat_ff)
      begin
        bp_ff <= {stat_new_ff[SR_BP_HI_POS], stat_new_ff[SR_BP_LO_POS]};
        hwpe_ff <= stat_new_ff[SR_HWPE_POS];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      stat_new_ff <= 8'h00;
      sdata_got_ff <= 1'b0;
      kind_stat_ff <= 1'b0;
    end
    else
    begin
      if (cs_fall)
        sdata_got_ff <= 1'b0;
      else if (byte_done && (state_ff == S_SDATA))
        sdata_got_ff <= 1'b1;
      if (byte_done && (state_ff == S_SDATA))
        stat_new_ff <= rx_byte;
      if (wr_go)
        kind_stat_ff <= stat_go;
    end
  end

  // ----------------------------------------
  // Page buffer and drain into the array
  // ----------------------------------------
  // The buffer is left alone while a cycle drains it, even if a status poll restarts the link.
  always_ff @(posedge CORE_CLK)
  begin
    if (byte_done && (state_ff == S_WDATA))
      page_mem[page_off] <= rx_byte;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      page_vld_ff <= '0;
      drain_ff <= 1'b0;
      drain_idx_ff <= '0;
      page_base_ff <= '0;
    end
    else
    begin
      if (cs_fall && !busy)
        page_vld_ff <= '0;
      else if (byte_done && (state_ff == S_WDATA))
        page_vld_ff[page_off] <= 1'b1;
      if (arr_go)
      begin
        drain_ff <= 1'b1;
        drain_idx_ff <= '0;
        page_base_ff <= addr_ff[15:PAGE_BITS];
      end
      else if (drain_ff)
      begin
        drain_idx_ff <= drain_idx_ff + PAGE_BITS'(1);
        drain_ff <= (drain_idx_ff != PAGE_BITS'(PAGE_BYTES - 1));
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      mem_req_ff <= '0;
    else if (drain_ff)
    begin
      mem_req_ff.we <= page_vld_ff[drain_idx_ff] && !is_protected(drain_addr, bp_ff);
      mem_req_ff.addr <= drain_addr;
      mem_req_ff.data <= page_mem[drain_idx_ff];
    end
    else
    begin
      mem_req_ff.we <= 1'b0;
      mem_req_ff.addr <= addr_ff;
      mem_req_ff.data <= 8'h00;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // A new byte is fetched on the falling edge that opens it, so the array has half a bit to answer.
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      so_ff <= 1'b0;
      out_shift_ff <= 8'h00;
      tx_started_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end
    else
    begin
      if (tx_edge && tx_state && (bit_cnt_ff == 3'h0))
      begin
        so_ff <= tx_byte[7];
        out_shift_ff <= {tx_byte[6:0], 1'b0};
      end
      else if (tx_edge && tx_state)
      begin
        so_ff <= out_shift_ff[7];
        out_shift_ff <= {out_shift_ff[6:0], 1'b0};
      end
      if (cs_n_s || cs_fall)
        tx_started_ff <= 1'b0;
      else if (tx_edge && tx_state)
        tx_started_ff <= 1'b1;
      so_oe_ff <= tx_started_ff && tx_state && !cs_n_s && !paused_ff;
    end
  end

  assign SO = so_ff;
  assign SO_OE = so_oe_ff;
  assign MEM_REQ = mem_req_ff;
  assign BUSY = busy;
endmodule // eep_core

// ---- tb/eep_checker.sv ----
// Concurrent checks on the ports of the serial EEPROM core.
`timescale 1ns/1ps
module eep_checker #(
  parameter int WC_CYCLES = 500000
) (
  input wire logic CORE_CLK, // Core clock.
  input wire logic NRST, // Reset, active low.
  input wire logic CS_N, // Chip select pin.
  input wire logic SCK, // Serial clock pin.
  input wire logic HOLD_N, // Pause pin.
  input wire logic SO, // Serial data out value.
  input wire logic SO_OE, // Serial data out enable.
  input wire eep_pkg::eep_mem_req_type MEM_REQ, // Array request.
  input wire logic BUSY // Write cycle in progress.
);
  import eep_pkg::*;
  int unsigned busy_cnt_ff;
  logic we_seen_ff;
  logic [15:6] we_page_ff;
  // Counts busy cycles and remembers the page of the last byte programmed.
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_cnt_ff <= 0;
      we_seen_ff <= 1'b0;
      we_page_ff <= '0;
    end
    else
    begin
      busy_cnt_ff <= BUSY ? busy_cnt_ff + 1 : 0;
      we_seen_ff <= MEM_REQ.we | (we_seen_ff & BUSY);
      we_page_ff <= MEM_REQ.we ? MEM_REQ.addr[15:6] : we_page_ff;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence s_deselected;
    CS_N [*6];
  endsequence
  sequence s_paused;
    !HOLD_N [*6];
  endsequence
  property p_so_off_deselected;
    s_deselected |-> !SO_OE;
  endproperty
  a_so_off_deselected: assert property (p_so_off_deselected) else $error("SO driven while deselected");
  property p_so_off_paused;
    s_paused |-> !SO_OE;
  endproperty
  a_so_off_paused: assert property (p_so_off_paused) else $error("SO driven while paused");
  property p_oe_rise;
    $rose(SO_OE) |-> !CS_N && HOLD_N;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("SO enabled outside a selected frame");
  property p_so_stable;
    SO_OE && $past(SO_OE) && $changed(SO) |-> !SCK;
  endproperty
  a_so_stable: assert property (p_so_stable) else $error("SO changed while SCK high");
  property p_busy_at_cs_rise;
    $rose(BUSY) |-> CS_N && $past(CS_N, 2);
  endproperty
  a_busy_at_cs_rise: assert property (p_busy_at_cs_rise) else $error("write cycle began while selected");
  property p_busy_len;
    $fell(BUSY) |-> busy_cnt_ff == WC_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_we_in_busy;
    MEM_REQ.we |-> ##[0:1] BUSY;
  endproperty
  a_we_in_busy: assert property (p_we_in_busy) else $error("array written outside a write cycle");
  property p_we_page;
    MEM_REQ.we && we_seen_ff |-> MEM_REQ.addr[15:6] == we_page_ff;
  endproperty
  a_we_page: assert property (p_we_page) else $error("page write left its page");
endmodule // eep_checker

bind eep_core eep_checker #(.WC_CYCLES(WC_CYCLES)) u_eep_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .CS_N(CS_N),
  .SCK(SCK), .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE), .MEM_REQ(MEM_REQ), .BUSY(BUSY));

// ---- tb/eep_spi_master.sv ----
// Mode 0 serial bus master model driving the pins of the core.
`timescale 1ns/1ps
module eep_spi_master (
  input wire logic clk, // Core clock that paces the serial clock.
  output logic cs_n, // Chip select, active low.
  output logic sck, // Serial clock, idle low.
  output logic si, // Serial data to the core.
  output logic hold_n, // Pause request, active low.
  input wire logic so, // Resolved serial data from the core.
  input wire logic so_oe // Drive enable of so.
);
  logic hold_oe;
  logic oe_any;
  initial
  begin
    {cs_n, sck, si, hold_n, hold_oe, oe_any} = 6'b100100;
  end
  always @(posedge clk)
  begin
    if (so_oe)
      oe_any <= 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic sel();
    oe_any = 1'b0;
    cs_n = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask
  // Shifts nbits from the top of tx, pausing before bit hold_at.
  task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      if (i == hold_at)
      begin
        hold_n = 1'b0;
        half();
        hold_oe = so_oe;
        repeat (2)
        begin
          sck = 1'b1;
          si = ~si;
          half();
          sck = 1'b0;
          half();
        end
        hold_n = 1'b1;
        half();
      end
      si = tx[i];
      half();
      sck = 1'b1;
      rx[i] = so;
      half();
      sck = 1'b0;
    end
  endtask
endmodule // eep_spi_master

// ---- tb/eep_core_tb.sv ----
// Self-checking bench of the serial EEPROM core.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module eep_core_tb;
  import eep_pkg::*;
  localparam int WC = 1500;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  wire cs_n, sck, si, hold_n, so_line;
  logic so, so_oe, busy;
  eep_mem_req_type mem_req;
  logic [7:0] mem_rd, st, rx;
  logic [7:0] mem [0:16383];
  logic [13:0] ra;
  int errors = 0;
  int compares = 0;
  always #5 clk = ~clk;
  assign mem_rd = mem[mem_req.addr[13:0]];
  assign so_line = so_oe ? so : 1'bz;
  always @(posedge clk)
  begin
    if (mem_req.we)
      mem[mem_req.addr[13:0]] <= mem_req.data;
  end
  eep_core #(.ADDR_W(14), .WC_CYCLES(WC)) dut_u (.CORE_CLK(clk), .NRST(nrst), .CS_N(cs_n), .SCK(sck), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe), .MEM_REQ(mem_req), .MEM_RD_DATA(mem_rd), .BUSY(busy));
  eep_spi_master m_u (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so_line), .so_oe(so_oe));
  task automatic cmd1(input logic [7:0] op);
    m_u.sel();
    m_u.xfer(op, 8, -1, rx);
    m_u.desel();
  endtask
  task automatic read_status_cmd(input logic [7:0] op, input int hold_at, output logic [7:0] s);
    m_u.sel();
    m_u.xfer(op, 8, -1, rx);
    m_u.xfer(8'h00, 8, hold_at, s);
    m_u.desel();
  endtask
  task automatic wait_busy();
    for (int k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk);
    for (int k = 0; k < 2 * WC && busy === 1'b1; k++) @(negedge clk);
  endtask
  task automatic page_wr(input logic en, input logic [15:0] a, input int n, input logic [7:0] v);
    if (en)
      cmd1(8'h06);
    m_u.sel();
    m_u.xfer(8'h02, 8, -1, rx);
    m_u.xfer(a[15:8], 8, -1, rx);
    m_u.xfer(a[7:0], 8, -1, rx);
    for (int k = 0; k < n; k++) m_u.xfer(v + k[7:0], 8, -1, rx);
    m_u.desel();
  endtask
  task automatic wr_status(input logic [7:0] v);
    cmd1(8'h06);
    m_u.sel();
    m_u.xfer(8'h01, 8, -1, rx);
    m_u.xfer(v, 8, -1, rx);
    m_u.desel();
    wait_busy();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5a;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    read_status_cmd(8'h05, -1, st);
    `CHK("status after reset", 8'h00, st)
    cmd1(8'h0e);
    read_status_cmd(8'h0d, 3, st);
    `CHK("status with latch set", 8'h02, st)
    `CHK("SO enable in pause", 1'b0, m_u.hold_oe)
    cmd1(8'h04);
    read_status_cmd(8'h05, -1, st);
    `CHK("status after clear", 8'h00, st)
    $display("test latch and pause done");
    m_u.sel();
    m_u.xfer(8'h03, 8, -1, rx);
    m_u.xfer(8'hff, 8, -1, rx);
    m_u.xfer(8'hfe, 8, -1, rx);
    for (int k = 0; k < 3; k++)
    begin
      ra = 14'h3ffe + k[13:0];
      m_u.xfer(8'h00, 8, -1, rx);
      `CHK("read data", ra[7:0] ^ 8'h5a, rx)
    end
    m_u.desel();
    $display("test wrapping read done");
    page_wr(1'b0, 16'h0010, 1, 8'h33);
    `CHK("busy after unlatched write", 1'b0, busy)
    `CHK("unlatched write byte", 8'h4a, mem[16])
    page_wr(1'b1, 16'h007e, 3, 8'hc0);
    cmd1(8'h06);
    read_status_cmd(8'h05, -1, st);
    `CHK("status while busy", 8'hff, st)
    m_u.sel();
    m_u.xfer(8'h03, 8, -1, rx);
    m_u.xfer(8'h00, 8, -1, rx);
    m_u.xfer(8'h40, 8, -1, rx);
    m_u.xfer(8'h00, 8, -1, rx);
    m_u.desel();
    `CHK("SO enable for read while busy", 1'b0, m_u.oe_any)
    wait_busy();
    read_status_cmd(8'h05, -1, st);
    `CHK("status after write", 8'h00, st)
    `CHK("page byte 7e", 8'hc0, mem[14'h7e])
    `CHK("page byte 7f", 8'hc1, mem[14'h7f])
    `CHK("page byte 40", 8'hc2, mem[14'h40])
    `CHK("page byte 80", 8'hda, mem[14'h80])
    $display("test page write done");
    wr_status(8'hff);
    read_status_cmd(8'h05, -1, st);
    `CHK("status written", 8'h8c, st)
    page_wr(1'b1, 16'h0100, 1, 8'h11);
    wait_busy();
    `CHK("write to protected all", 8'h5a, mem[14'h100])
    wp_n = 1'b0;
    wr_status(8'h00);
    read_status_cmd(8'h05, -1, st);
    `CHK("status under hw protect", 8'h8c, st & 8'hfc)
    wp_n = 1'b1;
    wr_status(8'h84);
    read_status_cmd(8'h05, -1, st);
    `CHK("status quarter level", 8'h84, st)
    page_wr(1'b1, 16'h3000, 1, 8'h22);
    wait_busy();
    `CHK("write to top quarter", 8'h5a, mem[14'h3000])
    page_wr(1'b1, 16'h2fff, 1, 8'h23);
    wait_busy();
    `CHK("write below top quarter", 8'h23, mem[14'h2fff])
    $display("test protection done");
    cmd1(8'h06);
    m_u.sel();
    m_u.xfer(8'h01, 8, -1, rx);
    m_u.xfer(8'h00, 8, -1, rx);
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    wp_n = 1'b1;
    m_u.desel();
    `CHK("busy after aborted status write", 1'b0, busy)
    read_status_cmd(8'h05, -1, st);
    `CHK("status after abort", 8'h84, st & 8'hfc)
    page_wr(1'b1, 16'h0020, 0, 8'h00);
    m_u.sel();
    m_u.xfer(8'h02, 8, -1, rx);
    m_u.xfer(8'h00, 8, -1, rx);
    m_u.xfer(8'h20, 8, -1, rx);
    m_u.xfer(8'h77, 8, -1, rx);
    m_u.xfer(8'h88, 4, -1, rx);
    m_u.desel();
    wait_busy();
    `CHK("partial byte write", 8'h7a, mem[14'h20])
    m_u.sel();
    m_u.xfer(8'h07, 8, -1, rx);
    m_u.xfer(8'h00, 8, -1, rx);
    m_u.desel();
    `CHK("SO enable after unknown opcode", 1'b0, m_u.oe_any)
    $display("test abort and refusal done");
    print_verdict();
  end
endmodule // eep_core_tb
